//--- src/mode_cfg_pkg.sv
/*
 * Constants for the start-up and failure-behaviour configuration block.
 * Assumes a single 25 MHz clock and a synchronous active-low power-on reset.
 */
// Contract
// R1: Mode field follows writes; restart clears it
// R2: Power-on enters init mode, long window
// R3: Test pin at power-on selects development mode
// R4: Pull-down on interrupt pin during reset delay
// R5: Filtered strap latched at reset output rise
// R6: Power-on flag set: resample on every reset
// R7: Host clears power-on flag after initialisation
// R8: Unstable strap stores zero, fail-safe
// R9: Strap high: watchdog failure gives restart
// R10: Strap low: watchdog failure gives fail-safe
// R11: Strap low, config zero: first failure restarts
// R12: Overvoltage reset disabled: flag only
// R13: Overvoltage, enabled, strap high: restart
// R14: Overvoltage, enabled, strap low: fail-safe
// R15: Overvoltage enabled: fail outputs at first event
// R16: Config bit and strap readable by host
// R17: Configuration held until power-on reset
// R18: Any command in init mode gives normal
// R19: Trigger in long window applies watchdog config
// R20: No trigger in long window: failure, restart
// R21: Wake events discarded in init mode
// R22: Restart leaves to normal after reset delay
// R23: Development mode stops the watchdog counter
// R24: Filter, reset delay, long window are parameters
package mode_cfg_pkg;

    typedef enum logic [2:0] {
        MODE_INIT,
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_RESTART,
        MODE_FAILSAFE
    } op_mode_t;

    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned FILTER_TIME_US  = 64;
    localparam int unsigned RESET_DELAY_US  = 10_000;
    localparam int unsigned LONG_WINDOW_MS  = 200;

    // Cycle counts from the times at the clock rate
    localparam int unsigned FILTER_CYCLES   = (FILTER_TIME_US * (CLK_HZ / 1_000_000));
    localparam int unsigned RESET_DELAY_CYC = RESET_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int unsigned LONG_WINDOW_CYC = LONG_WINDOW_MS * (CLK_HZ / 1_000);

    localparam logic [1:0] MODE_FIELD_RESET = 2'h0;
    localparam logic       STRAP_RESET      = 1'h0;
    localparam logic       CFG_BIT_RESET    = 1'h1;

endpackage : mode_cfg_pkg

//--- src/strap_filter.sv
/*
 * Continuous filter on the strap level.
 * Assumes the input is already synchronised to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module strap_filter #(
    parameter int unsigned FILTER_CYCLES = 1600
) (
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst_b,
    // Sampling
    input  wire logic i_active,
    input  wire logic i_level,
    output logic      o_stable_high
);
    logic [31:0] cnt_r;
    logic        prev_r;

    // Count unchanged level; unstable or low gives zero (see R8)
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || !i_active) begin
            cnt_r         <= 32'h0;
            prev_r        <= 1'b0;
            o_stable_high <= 1'b0;
        end else begin
            prev_r <= i_level;
            if (i_level != prev_r) begin
                cnt_r         <= 32'h0;
                o_stable_high <= 1'b0;
            end else if (cnt_r >= FILTER_CYCLES) begin
                o_stable_high <= i_level; // see R5
            end else begin
                cnt_r <= cnt_r + 32'h1;
            end
        end
    end
endmodule : strap_filter
`default_nettype wire

//--- src/delay_timer.sv
/*
 * Restartable down-counter that pulses once when a window expires.
 * Assumes one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module delay_timer (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_b,
    // Control
    input  wire logic        i_start,
    input  wire logic        i_run,
    input  wire logic [31:0] i_load,
    output logic             o_done
);
    logic [31:0] cnt_r;
    logic        busy_r;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            cnt_r  <= 32'h0;
            busy_r <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                cnt_r  <= i_load;
                busy_r <= 1'b1;
            end else if (busy_r && i_run) begin
                if (cnt_r <= 32'h1) begin
                    busy_r <= 1'b0;
                    o_done <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 32'h1;
                end
            end
        end
    end
endmodule : delay_timer
`default_nettype wire

//--- src/init_cfg_ctrl.sv
/*
 * Power-on entry, strap capture and failure-behaviour selection of the
 * mode state machine.
 * Assumes i_rst_b is the power-on reset (supply below falling threshold),
 * host commands arrive as one-cycle pulses on the clock, pins are async.
 */
`timescale 1ns/1ps
`default_nettype none
module init_cfg_ctrl #(
    parameter int unsigned FILTER_CYCLES   = mode_cfg_pkg::FILTER_CYCLES,   // see R24
    parameter int unsigned RESET_DELAY_CYC = mode_cfg_pkg::RESET_DELAY_CYC, // see R24
    parameter int unsigned LONG_WINDOW_CYC = mode_cfg_pkg::LONG_WINDOW_CYC  // see R24
) (
    // Clock and power-on reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_b,
    // Pins
    input  wire logic       i_int_pin,
    input  wire logic       i_fail_test_shared_pin,
    input  wire logic       i_main_regulator_ok,
    input  wire logic       i_main_overvoltage,
    output logic            o_int_pulldown_en,
    output logic            o_reset_output,
    output logic            o_fail_outputs,
    // Host command strobes
    input  wire logic       i_spi_cmd,
    input  wire logic       i_mode_wr,
    input  wire logic [1:0] i_mode_wdata,
    input  wire logic       i_wd_trigger,
    input  wire logic       i_cfg_wr,
    input  wire logic       i_cfg_wdata,
    input  wire logic       i_ov_rst_wr,
    input  wire logic       i_ov_rst_wdata,
    input  wire logic       i_por_clr,
    input  wire logic       i_ov_flag_clr,
    // Failure and wake events
    input  wire logic       i_wd_fail,
    input  wire logic       i_wake_event,
    // Status
    output logic [1:0]      o_operating_mode_field,
    output logic [2:0]      o_mode,
    output logic            o_hw_cfg_bit,
    output logic            o_strap_pullup_state,
    output logic            o_overvoltage_reset_enable,
    output logic            o_main_overvoltage_flag,
    output logic            o_por_flag,
    output logic            o_dev_mode,
    output logic            o_wd_enable,
    output logic            o_wd_cfg_load,
    output logic            o_wake_pending
);
    mode_cfg_pkg::op_mode_t mode_r;
    mode_cfg_pkg::op_mode_t mode_nxt;

    logic [1:0] int_sync_r;
    logic [1:0] test_sync_r;
    logic [1:0] vok_sync_r;
    logic [1:0] ov_sync_r;
    logic       ov_prev_r;
    logic       ov_rise;
    logic       strap_filt;
    logic       in_delay_r;
    logic       delay_start;
    logic       delay_done;
    logic       win_done;
    logic       por_entry_r;
    logic       first_fail_r;
    logic       fail_event;
    logic       ov_act;
    logic       wd_act;

    // Two-stage synchronisers for pins
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            int_sync_r  <= 2'h0;
            test_sync_r <= 2'h3;
            vok_sync_r  <= 2'h0;
            ov_sync_r   <= 2'h0;
        end else begin
            int_sync_r  <= {int_sync_r[0], i_int_pin};
            test_sync_r <= {test_sync_r[0], i_fail_test_shared_pin};
            vok_sync_r  <= {vok_sync_r[0], i_main_regulator_ok};
            ov_sync_r   <= {ov_sync_r[0], i_main_overvoltage};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            ov_prev_r <= 1'b0;
        end else begin
            ov_prev_r <= ov_sync_r[1];
        end
    end

    assign ov_rise = ov_sync_r[1] && !ov_prev_r;

    // Reset delay runs while regulator is up and restart/init has reset low
    assign delay_start = !in_delay_r && !o_reset_output && vok_sync_r[1]
                         && (mode_r == mode_cfg_pkg::MODE_RESTART || por_entry_r);

    delay_timer u_reset_delay (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_start   (delay_start),
        .i_run     (vok_sync_r[1] && !fail_event),
        .i_load    (32'(RESET_DELAY_CYC)),
        .o_done    (delay_done)
    );

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            in_delay_r <= 1'b0;
        end else if (delay_done || !vok_sync_r[1]) begin
            in_delay_r <= 1'b0;
        end else if (delay_start) begin
            in_delay_r <= 1'b1;
        end
    end

    // Reset output low in restart/fail-safe or on regulator loss, high after the delay
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_reset_output <= 1'b0;
        end else if (!vok_sync_r[1] || mode_nxt == mode_cfg_pkg::MODE_RESTART
                     || mode_nxt == mode_cfg_pkg::MODE_FAILSAFE) begin
            o_reset_output <= 1'b0;
        end else if (delay_done) begin
            o_reset_output <= 1'b1;
        end
    end

    // Pull-down only during reset delay while power-on flag is set
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_int_pulldown_en <= 1'b0;
        end else begin
            o_int_pulldown_en <= in_delay_r && o_por_flag && !delay_done; // see R4, R6
        end
    end

    strap_filter #(
        .FILTER_CYCLES (FILTER_CYCLES)
    ) u_strap_filter (
        .i_ref_clk     (i_ref_clk),
        .i_rst_b       (i_rst_b),
        .i_active      (o_int_pulldown_en),
        .i_level       (int_sync_r[1]),
        .o_stable_high (strap_filt)
    );

    // Strap latched at each reset-output rise while power-on flag is set; else held
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_strap_pullup_state <= mode_cfg_pkg::STRAP_RESET; // see R17
        end else if (delay_done && o_por_flag && vok_sync_r[1]) begin
            o_strap_pullup_state <= strap_filt; // see R5, R6, R8
        end
    end

    // Power-on flag; host clears it (see R7)
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_por_flag <= 1'b1;
        end else if (i_por_clr) begin
            o_por_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            por_entry_r <= 1'b1;
        end else if (delay_done) begin
            por_entry_r <= 1'b0;
        end
    end

    // Development mode caught in init from grounded test pin
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_dev_mode <= 1'b0;
        end else if (mode_r == mode_cfg_pkg::MODE_INIT && !test_sync_r[1]) begin
            o_dev_mode <= 1'b1; // see R3, R23
        end
    end

    // Config bits written by host
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_hw_cfg_bit               <= mode_cfg_pkg::CFG_BIT_RESET;
            o_overvoltage_reset_enable <= 1'b0;
        end else begin
            if (i_cfg_wr) begin
                o_hw_cfg_bit <= i_cfg_wdata; // see R16
            end
            if (i_ov_rst_wr) begin
                o_overvoltage_reset_enable <= i_ov_rst_wdata;
            end
        end
    end

    // Overvoltage flag: set wins over clear
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_main_overvoltage_flag <= 1'b0;
        end else if (ov_rise) begin
            o_main_overvoltage_flag <= 1'b1; // see R12
        end else if (i_ov_flag_clr) begin
            o_main_overvoltage_flag <= 1'b0;
        end
    end

    // Long open window of init mode
    delay_timer u_long_window (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_start   (por_entry_r && delay_done),
        .i_run     (mode_r == mode_cfg_pkg::MODE_INIT && !o_dev_mode && !i_wd_trigger),
        .i_load    (32'(LONG_WINDOW_CYC)),
        .o_done    (win_done)
    );

    assign o_wd_enable   = !o_dev_mode; // see R23
    assign o_wd_cfg_load = i_wd_trigger; // see R19
    assign wd_act        = (i_wd_fail && !o_dev_mode) || win_done; // see R20
    assign ov_act        = ov_rise && o_overvoltage_reset_enable; // see R12
    assign fail_event    = wd_act || ov_act;

    // Count watchdog failures for second-failure configs
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            first_fail_r <= 1'b0;
        end else if (wd_act) begin
            first_fail_r <= 1'b1;
        end
    end

    // Fail outputs: first or second watchdog failure, first overvoltage
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_fail_outputs <= 1'b0;
        end else if (ov_act) begin
            o_fail_outputs <= 1'b1; // see R15
        end else if (wd_act && (o_hw_cfg_bit || first_fail_r)) begin
            o_fail_outputs <= 1'b1; // see R9, R10
        end
    end

    // Mode transitions
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            mode_cfg_pkg::MODE_INIT: begin
                if (i_spi_cmd) begin
                    mode_nxt = mode_cfg_pkg::MODE_NORMAL; // see R18
                end
            end
            mode_cfg_pkg::MODE_RESTART: begin
                if (delay_done) begin
                    mode_nxt = mode_cfg_pkg::MODE_NORMAL; // see R22
                end
            end
            mode_cfg_pkg::MODE_FAILSAFE: begin
                if (i_wake_event) begin
                    mode_nxt = mode_cfg_pkg::MODE_RESTART;
                end
            end
            mode_cfg_pkg::MODE_NORMAL, mode_cfg_pkg::MODE_STOP,
            mode_cfg_pkg::MODE_SLEEP: begin
                if (i_mode_wr) begin
                    mode_nxt = mode_cfg_pkg::op_mode_t'({1'b0, i_mode_wdata}); // see R1
                    if (i_mode_wdata == 2'h0) begin
                        mode_nxt = mode_cfg_pkg::MODE_NORMAL;
                    end
                end
            end
            default: begin
                mode_nxt = mode_cfg_pkg::MODE_INIT;
            end
        endcase
        if (win_done) begin
            mode_nxt = mode_cfg_pkg::MODE_RESTART; // see R20
        end else if (wd_act) begin
            if (o_strap_pullup_state || (!o_hw_cfg_bit && !first_fail_r)) begin
                mode_nxt = mode_cfg_pkg::MODE_RESTART; // see R9, R11
            end else begin
                mode_nxt = mode_cfg_pkg::MODE_FAILSAFE; // see R10
            end
        end else if (ov_act) begin
            mode_nxt = o_strap_pullup_state ? mode_cfg_pkg::MODE_RESTART   // see R13
                                            : mode_cfg_pkg::MODE_FAILSAFE; // see R14
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            mode_r <= mode_cfg_pkg::MODE_INIT; // see R2
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Mode field follows host writes, cleared through restart
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_operating_mode_field <= mode_cfg_pkg::MODE_FIELD_RESET;
        end else if (mode_nxt == mode_cfg_pkg::MODE_RESTART) begin
            o_operating_mode_field <= mode_cfg_pkg::MODE_FIELD_RESET; // see R1
        end else if (i_mode_wr && mode_r inside {mode_cfg_pkg::MODE_NORMAL,
                     mode_cfg_pkg::MODE_STOP, mode_cfg_pkg::MODE_SLEEP}) begin
            o_operating_mode_field <= i_mode_wdata;
        end
    end

    // Wake latch, discarded while in init
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || mode_r == mode_cfg_pkg::MODE_INIT) begin
            o_wake_pending <= 1'b0; // see R21
        end else if (i_wake_event) begin
            o_wake_pending <= 1'b1;
        end else if (i_spi_cmd) begin
            o_wake_pending <= 1'b0;
        end
    end

    assign o_mode = mode_r;

endmodule : init_cfg_ctrl
`default_nettype wire

//--- dv/init_cfg_ctrl_sva.sv
/* Port assertions for the init and failure configuration block.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module init_cfg_ctrl_sva (
    // Clock and reset
    input wire logic       i_ref_clk,
    input wire logic       i_rst_b,
    // Strobes
    input wire logic       i_spi_cmd,
    input wire logic       i_wd_fail,
    input wire logic       i_wake_event,
    input wire logic       i_cfg_wr,
    input wire logic       i_cfg_wdata,
    // Status
    input wire logic       o_int_pulldown_en,
    input wire logic       o_reset_output,
    input wire logic       o_fail_outputs,
    input wire logic [1:0] o_operating_mode_field,
    input wire logic [2:0] o_mode,
    input wire logic       o_hw_cfg_bit,
    input wire logic       o_strap_pullup_state,
    input wire logic       o_overvoltage_reset_enable,
    input wire logic       o_main_overvoltage_flag,
    input wire logic       o_por_flag,
    input wire logic       o_dev_mode,
    input wire logic       o_wake_pending
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);
    property p_init_entry;
        $rose(i_rst_b) |-> o_mode == 3'h0 && o_por_flag;
    endproperty
    a_init_entry: assert property (p_init_entry) else $error("not init after reset");
    property p_pulldown;
        o_int_pulldown_en |-> !o_reset_output;
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("pull-down out of delay");
    property p_strap_hold;
        $changed(o_strap_pullup_state) |-> o_reset_output && o_por_flag;
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap moved");
    property p_init_cmd;
        o_mode == 3'h0 && o_reset_output && i_spi_cmd && !i_wd_fail |=> o_mode == 3'h1;
    endproperty
    a_init_cmd: assert property (p_init_cmd) else $error("command kept init");
    property p_wake_drop;
        o_mode == 3'h0 && i_wake_event |=> !o_wake_pending;
    endproperty
    a_wake_drop: assert property (p_wake_drop) else $error("wake kept in init");
    property p_ov_off;
        !o_overvoltage_reset_enable && $rose(o_main_overvoltage_flag)
            |-> $stable(o_mode) && $stable(o_fail_outputs);
    endproperty
    a_ov_off: assert property (p_ov_off) else $error("ov acted while off");
    property p_ov_on;
        o_overvoltage_reset_enable && $rose(o_main_overvoltage_flag)
            |-> ##[0:2] o_fail_outputs && o_mode == (o_strap_pullup_state ? 3'h4 : 3'h5);
    endproperty
    a_ov_on: assert property (p_ov_on) else $error("ov reaction wrong");
    property p_wd_fail;
        (o_mode == 3'h1 || o_mode == 3'h2) && i_wd_fail && !o_dev_mode
            && (o_strap_pullup_state || o_hw_cfg_bit)
            |=> o_mode == (o_strap_pullup_state ? 3'h4 : 3'h5)
                && (o_fail_outputs || !o_hw_cfg_bit);
    endproperty
    a_wd_fail: assert property (p_wd_fail) else $error("wd failure reaction");
    property p_dev_ignore;
        o_dev_mode && i_wd_fail |=> $stable(o_fail_outputs) && o_mode != 3'h4 && o_mode != 3'h5;
    endproperty
    a_dev_ignore: assert property (p_dev_ignore) else $error("dev mode failed");
    property p_field_clear;
        o_mode == 3'h4 |=> o_operating_mode_field == 2'h0;
    endproperty
    a_field_clear: assert property (p_field_clear) else $error("field kept");
    property p_cfg_write;
        $changed(o_hw_cfg_bit) |-> $past(i_cfg_wr) && o_hw_cfg_bit == $past(i_cfg_wdata);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("cfg bit moved");
    c_restart: cover property (o_mode == 3'h4);
    c_failsafe: cover property (o_mode == 3'h5);
    c_ov_flag: cover property ($rose(o_main_overvoltage_flag));
endmodule : init_cfg_ctrl_sva
bind init_cfg_ctrl init_cfg_ctrl_sva i_sva (
    .i_ref_clk, .i_rst_b, .i_spi_cmd, .i_wd_fail, .i_wake_event, .i_cfg_wr, .i_cfg_wdata,
    .o_int_pulldown_en, .o_reset_output, .o_fail_outputs, .o_operating_mode_field, .o_mode,
    .o_hw_cfg_bit, .o_strap_pullup_state, .o_overvoltage_reset_enable,
    .o_main_overvoltage_flag, .o_por_flag, .o_dev_mode, .o_wake_pending
);
`default_nettype wire

//--- dv/strap_model.sv
/* Strap circuit on the interrupt pin: optional pull-up or noise.
   Assumes the block's pull-down enable; a bare pin floats. */
`timescale 1ns/1ps
`default_nettype none
module strap_model (
    // Clock and setup
    input  wire logic i_ref_clk,
    input  wire logic i_pullup_fit,
    input  wire logic i_noisy,
    input  wire logic i_pulldown_en,
    // Pin
    output logic      o_int_pin
);
    logic toggle_r = 1'b0;
    always_ff @(posedge i_ref_clk) begin
        toggle_r <= ~toggle_r;
    end
    // Noise, pull-up, pull-down, else floating
    always_comb begin
        if (i_noisy) o_int_pin = toggle_r;
        else if (i_pullup_fit) o_int_pin = 1'b1;
        else if (i_pulldown_en) o_int_pin = 1'b0;
        else o_int_pin = toggle_r;
    end
endmodule : strap_model
`default_nettype wire

//--- dv/init_cfg_ctrl_test.sv
/* Self-checking bench for the init and failure configuration block.
   Assumes short count parameters and the strap model on the pin. */
`timescale 1ns/1ps
`default_nettype none
module init_cfg_ctrl_test;
    localparam int unsigned DLY = 20;
    localparam int unsigned WIN = 50;
    localparam int CMD = 0, FAIL = 1, PORC = 2, WAKE = 3, OVC = 4, CFG = 5, OVE = 6, MWR = 7;
    logic i_ref_clk = 1'b0, i_rst_b = 1'b0, i_int_pin, i_fail_test_shared_pin = 1'b1;
    logic i_main_regulator_ok = 1'b0, i_main_overvoltage = 1'b0, i_spi_cmd, i_mode_wr;
    logic i_wd_trigger = 1'b0, i_cfg_wr, i_cfg_wdata = 1'b0, i_ov_rst_wr, i_ov_rst_wdata = 1'b0;
    logic [1:0] i_mode_wdata = 2'h0;
    logic i_por_clr, i_ov_flag_clr, i_wd_fail, i_wake_event, pull_fit = 1'b0, noisy = 1'b0;
    logic [7:0] strb = 8'h0;
    assign {i_mode_wr, i_ov_rst_wr, i_cfg_wr, i_ov_flag_clr, i_wake_event, i_por_clr, i_wd_fail,
        i_spi_cmd} = strb;
    logic o_int_pulldown_en, o_reset_output, o_fail_outputs, o_hw_cfg_bit, o_por_flag;
    logic [1:0] o_operating_mode_field;
    logic [2:0] o_mode;
    logic o_strap_pullup_state, o_overvoltage_reset_enable, o_main_overvoltage_flag;
    logic o_dev_mode, o_wd_enable, o_wd_cfg_load, o_wake_pending;
    int n_errors = 0, check_count = 0, cycles = 0;
    always #20 i_ref_clk = ~i_ref_clk;
    init_cfg_ctrl #(.FILTER_CYCLES(4), .RESET_DELAY_CYC(DLY), .LONG_WINDOW_CYC(WIN)) i_dut (
        .i_ref_clk, .i_rst_b, .i_int_pin, .i_fail_test_shared_pin, .i_main_regulator_ok,
        .i_main_overvoltage, .o_int_pulldown_en, .o_reset_output, .o_fail_outputs,
        .i_spi_cmd, .i_mode_wr, .i_mode_wdata, .i_wd_trigger, .i_cfg_wr, .i_cfg_wdata,
        .i_ov_rst_wr, .i_ov_rst_wdata, .i_por_clr, .i_ov_flag_clr, .i_wd_fail, .i_wake_event,
        .o_operating_mode_field, .o_mode, .o_hw_cfg_bit, .o_strap_pullup_state,
        .o_overvoltage_reset_enable, .o_main_overvoltage_flag, .o_por_flag, .o_dev_mode,
        .o_wd_enable, .o_wd_cfg_load, .o_wake_pending);
    strap_model i_strap (.i_ref_clk, .i_pullup_fit(pull_fit), .i_noisy(noisy),
        .i_pulldown_en(o_int_pulldown_en), .o_int_pin(i_int_pin));
    task automatic step(input int n = 1);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : step
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic pulse(input int s);
        strb[s] = 1'b1;
        step();
        strb[s] = 1'b0;
    endtask : pulse
    task automatic wait_mode(input logic [2:0] m, input int lim);
        int k;
        k = 0;
        while (o_mode !== m && k < lim) begin
            step();
            k++;
        end
        chk("mode", o_mode, m);
    endtask : wait_mode
    task automatic ov_pulse;
        i_main_overvoltage = 1'b1;
        step(6);
    endtask : ov_pulse
    task automatic power_up(input logic pull, input logic nz, input logic tst);
        int k;
        i_rst_b = 1'b0;
        i_main_regulator_ok = 1'b0;
        pull_fit = pull;
        noisy = nz;
        i_fail_test_shared_pin = tst;
        step(20);
        i_rst_b = 1'b1;
        chk("reset mode", o_mode, 3'h0);
        i_main_regulator_ok = 1'b1;
        k = 0;
        while (o_reset_output !== 1'b1 && k < 200) begin
            if (k == 5) chk("pull-down", o_int_pulldown_en, 1'b1);
            step();
            k++;
        end
        chk("delay", k >= DLY && k <= DLY + 4, 1'b1);
        step();
        chk("pull-down off", o_int_pulldown_en, 1'b0);
        chk("strap", o_strap_pullup_state, pull && !nz);
        chk("dev", o_dev_mode, !tst);
        chk("init", o_mode, 3'h0);
        noisy = 1'b0;
    endtask : power_up
    task automatic t_dev_noisy;
        power_up(1'b1, 1'b1, 1'b0);
        chk("wd enable", o_wd_enable, 1'b0);
        step(WIN + 20);
        chk("dev init", o_mode, 3'h0);
        pulse(CMD);
        wait_mode(3'h1, 3);
        pulse(FAIL);
        step(3);
        chk("dev mode kept", o_mode, 3'h1);
        chk("dev fail", o_fail_outputs, 1'b0);
    endtask : t_dev_noisy
    task automatic t_strap_high;
        power_up(1'b1, 1'b0, 1'b1);
        chk("wd enable", o_wd_enable, 1'b1);
        pulse(WAKE);
        chk("wake lost", o_wake_pending, 1'b0);
        i_wd_trigger = 1'b1;
        #1;
        chk("wd cfg load", o_wd_cfg_load, 1'b1);
        step();
        i_wd_trigger = 1'b0;
        pulse(CMD);
        wait_mode(3'h1, 3);
        i_mode_wdata = 2'h2;
        pulse(MWR);
        step();
        chk("field", o_operating_mode_field, 2'h2);
        pulse(FAIL);
        wait_mode(3'h4, 2);
        chk("fail out", o_fail_outputs, 1'b1);
        pull_fit = 1'b0;
        step();
        chk("field clear", o_operating_mode_field, 2'h0);
        wait_mode(3'h1, 200);
        chk("relatch", o_strap_pullup_state, 1'b0);
        pulse(PORC);
        chk("por flag", o_por_flag, 1'b0);
        i_ov_rst_wdata = 1'b1;
        pulse(OVE);
        ov_pulse();
        chk("ov mode", o_mode, 3'h5);
        chk("ov fail", o_fail_outputs, 1'b1);
        chk("ov flag", o_main_overvoltage_flag, 1'b1);
        i_main_overvoltage = 1'b0;
    endtask : t_strap_high
    task automatic t_cfg0_low;
        power_up(1'b0, 1'b0, 1'b1);
        pulse(CMD);
        i_cfg_wdata = 1'b0;
        pulse(CFG);
        chk("cfg bit", o_hw_cfg_bit, 1'b0);
        ov_pulse();
        i_main_overvoltage = 1'b0;
        chk("ov only mode", o_mode, 3'h1);
        chk("ov only fail", o_fail_outputs, 1'b0);
        chk("ov only flag", o_main_overvoltage_flag, 1'b1);
        pulse(OVC);
        step();
        chk("ov clear", o_main_overvoltage_flag, 1'b0);
        pulse(FAIL);
        wait_mode(3'h4, 2);
        chk("first fail", o_fail_outputs, 1'b0);
        wait_mode(3'h1, 200);
        pulse(FAIL);
        wait_mode(3'h5, 2);
        chk("second fail", o_fail_outputs, 1'b1);
    endtask : t_cfg0_low
    task automatic t_window_ov;
        power_up(1'b1, 1'b0, 1'b1);
        pulse(PORC);
        i_cfg_wdata = 1'b0;
        pulse(CFG);
        step(WIN - 10);
        chk("still init", o_mode, 3'h0);
        wait_mode(3'h4, 30);
        chk("no fail yet", o_fail_outputs, 1'b0);
        pull_fit = 1'b0;
        wait_mode(3'h1, 200);
        chk("strap kept", o_strap_pullup_state, 1'b1);
        i_ov_rst_wdata = 1'b1;
        pulse(OVE);
        chk("ov enable", o_overvoltage_reset_enable, 1'b1);
        ov_pulse();
        chk("ov restart", o_mode, 3'h4);
        chk("ov fail", o_fail_outputs, 1'b1);
        i_main_overvoltage = 1'b0;
        wait_mode(3'h1, 200);
    endtask : t_window_ov
    initial begin
        t_dev_noisy();
        t_strap_high();
        t_cfg0_low();
        t_window_ov();
        finish_test();
    end
endmodule : init_cfg_ctrl_test
`default_nettype wire
